// File: verilog/grs_rate_filter.sv
// grs_rate_filter: internal rate, rate divisor, frame-sync insertion and FIFO push policy
// How it works
// - sample rate is internal rate divided by one plus divisor register
// - with divisor in effect the internal rate is 1 kHz
// - divisor acts only with bypass 00 and lowpass select 1 to 6
// - divided strobe updates data output registers and FIFO pushes
// - policy bit 6 set drops new entries when full, clear overwrites oldest
// - frame sync latched, toggles once until sample strobe captures it
// - internal rate 32k, 8k or 1k from bypass field and lowpass select
// - 2-bit bypass field comes from bits 1:0 of rate-sensor config
`timescale 1ns/100ps
`default_nettype none
module grs_rate_filter #(
    parameter int P_CYC_1K = grs_pkg::GRS_CYC_1K_DFLT
) (
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic [6:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_filter_bypass_field,
    input wire logic i_frame_sync_input,
    input wire grs_pkg::grs_sample_t i_raw_sample,
    input wire logic i_fifo_full,
    output grs_pkg::grs_sample_t o_rate_sample,
    output logic o_sample_strobe,
    output logic o_fifo_push,
    output logic o_fifo_overwrite
);
    import grs_pkg::*;

    // ==========================================================
    // helper functions
    function automatic grs_rate_t rate_pick(input logic [1:0] byp, input logic [2:0] lp);
        if (byp[GRS_BYP_BIT0] || byp == GRS_BYP_ALT) begin
            rate_pick = GRS_RATE_32K;
        end else if (lp == GRS_LP_MIN || lp == GRS_LP_MAX) begin
            rate_pick = GRS_RATE_8K;
        end else begin
            rate_pick = GRS_RATE_1K;
        end
    endfunction

    function automatic logic div_on(input logic [1:0] byp, input logic [2:0] lp);
        div_on = (byp == GRS_BYP_NONE) && (lp > GRS_LP_MIN) && (lp < GRS_LP_MAX);
    endfunction

    logic [7:0] rate_divisor_reg;
    logic [7:0] sync_cfg_reg;
    logic [GRS_TICK_W-1:0] tick_cnt_reg;
    logic [7:0] div_cnt_reg;
    logic sync_prev_reg;
    logic sync_latch_reg;
    logic sync_pend_reg;
    logic [2:0] lowpass_select;
    logic [2:0] frame_sync_slot;
    logic keep_old;
    logic div_active;
    grs_rate_t rate_sel;
    logic [GRS_TICK_W-1:0] period_m1;
    logic internal_tick;
    logic sample_stb;

    assign lowpass_select = sync_cfg_reg[GRS_CFG_LP_HI:GRS_CFG_LP_LO];
    assign frame_sync_slot = sync_cfg_reg[GRS_CFG_SLOT_HI:GRS_CFG_SLOT_LO];
    assign keep_old = sync_cfg_reg[GRS_CFG_KEEP_OLD_BIT];
    // bypass bits live in the rate-sensor config register outside this block
    assign rate_sel = rate_pick(i_filter_bypass_field, lowpass_select);
    assign div_active = div_on(i_filter_bypass_field, lowpass_select);

    // ==========================================================
    // register port
    // bit 7 is stored and read back but steers nothing
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rate_divisor_reg <= GRS_RATE_DIV_RST;
            sync_cfg_reg <= GRS_SYNC_CFG_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == GRS_ADDR_RATE_DIV) begin
                rate_divisor_reg <= i_reg_wdata;
            end
            if (i_reg_addr == GRS_ADDR_SYNC_CFG) begin
                sync_cfg_reg <= i_reg_wdata;
            end
        end
    end

    // read data held until the next read; unmapped addresses answer zero
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_reg_rdata <= GRS_RDATA_NONE;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                GRS_ADDR_RATE_DIV: begin
                    o_reg_rdata <= rate_divisor_reg;
                end
                GRS_ADDR_SYNC_CFG: begin
                    o_reg_rdata <= sync_cfg_reg;
                end
                default: begin
                    o_reg_rdata <= GRS_RDATA_NONE;
                end
            endcase
        end
    end

    // ==========================================================
    // internal rate tick
    // periods round down to whole cycles; 32k comes out at 781 clocks
    always_comb begin
        case (rate_sel)
            GRS_RATE_32K: begin
                period_m1 = GRS_TICK_W'(GRS_CYC_32K - 1);
            end
            GRS_RATE_8K: begin
                period_m1 = GRS_TICK_W'(GRS_CYC_8K - 1);
            end
            GRS_RATE_1K: begin
                period_m1 = GRS_TICK_W'(P_CYC_1K - 1);
            end
            default: begin
                period_m1 = GRS_TICK_W'(P_CYC_1K - 1);
            end
        endcase
    end

    // >= so that a switch to a faster rate mid-count cannot run away
    assign internal_tick = (tick_cnt_reg >= period_m1);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || internal_tick) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // rate divisor: one strobe per (1 + divisor) internal ticks
    assign sample_stb = internal_tick && (!div_active || div_cnt_reg >= rate_divisor_reg);

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            div_cnt_reg <= '0;
        end else if (sample_stb) begin
            div_cnt_reg <= '0;
        end else if (internal_tick) begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // frame-sync latch
    // one toggle is held until a strobe takes it; later edges are ignored till then.
    // an edge in the strobe cycle itself wins over the clear, so it is not lost
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sync_prev_reg <= 1'b0;
            sync_latch_reg <= 1'b0;
            sync_pend_reg <= 1'b0;
        end else begin
            sync_prev_reg <= i_frame_sync_input;
            if ((i_frame_sync_input != sync_prev_reg) && (!sync_pend_reg || sample_stb)) begin
                sync_latch_reg <= ~sync_latch_reg;
                sync_pend_reg <= 1'b1;
            end else if (sample_stb) begin
                sync_pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // data output registers at the divided rate
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rate_sample <= '0;
        end else if (sample_stb) begin
            o_rate_sample <= i_raw_sample;
            case (frame_sync_slot)
                GRS_SLOT_X: begin
                    o_rate_sample.x[GRS_SYNC_BIT] <= sync_latch_reg;
                end
                GRS_SLOT_Y: begin
                    o_rate_sample.y[GRS_SYNC_BIT] <= sync_latch_reg;
                end
                GRS_SLOT_Z: begin
                    o_rate_sample.z[GRS_SYNC_BIT] <= sync_latch_reg;
                end
                default: begin
                    o_rate_sample <= i_raw_sample;
                end
            endcase
        end
    end

    // ==========================================================
    // strobe and FIFO push policy
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_sample_strobe <= 1'b0;
            o_fifo_push <= 1'b0;
            o_fifo_overwrite <= 1'b0;
        end else begin
            o_sample_strobe <= sample_stb;
            o_fifo_push <= sample_stb && !(i_fifo_full && keep_old);
            o_fifo_overwrite <= sample_stb && i_fifo_full && !keep_old;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    a_drop_when_full: assert property (
        sample_stb && i_fifo_full && keep_old |=> !o_fifo_push)
        else $error("push while full in keep-old mode");
    a_overwrite_full: assert property (
        sample_stb && i_fifo_full && !keep_old |=> o_fifo_push && o_fifo_overwrite)
        else $error("overwrite push missing");
    a_div_skip: assert property (
        internal_tick && div_active && div_cnt_reg < rate_divisor_reg |=> !o_sample_strobe)
        else $error("strobe before divisor count");
    a_div_bypass: assert property (
        internal_tick && !div_active |=> o_sample_strobe)
        else $error("divisor applied while inactive");
    // the first tick right after a switch into 1k may come early through the >= compare
    a_rate_1k: assert property (
        internal_tick && div_active && $past(rate_sel) == GRS_RATE_1K
        |-> tick_cnt_reg == GRS_TICK_W'(P_CYC_1K - 1))
        else $error("divided rate not from 1 kHz");
    a_rate_32k: assert property (
        i_filter_bypass_field[GRS_BYP_BIT0] |-> rate_sel == GRS_RATE_32K)
        else $error("bypass did not pick 32k");
    a_sync_insert: assert property (
        sample_stb && frame_sync_slot == GRS_SLOT_X
        |=> o_rate_sample.x[GRS_SYNC_BIT] == $past(sync_latch_reg))
        else $error("frame sync bit not inserted");
    a_sync_hold: assert property (
        sync_pend_reg && !sample_stb |=> $stable(sync_latch_reg))
        else $error("latched sync toggled twice");
    a_spare_bit: assert property (
        i_reg_wr && i_reg_addr == GRS_ADDR_SYNC_CFG
        |=> sync_cfg_reg[GRS_CFG_SPARE_BIT] == $past(i_reg_wdata[GRS_CFG_SPARE_BIT]))
        else $error("config bit 7 not stored");

    c_div_strobe: cover property (internal_tick && div_active && rate_divisor_reg != '0 ##1 o_sample_strobe);
    c_drop: cover property (sample_stb && i_fifo_full && keep_old);
    c_overwrite: cover property (o_fifo_overwrite);
    c_sync_z: cover property (sample_stb && frame_sync_slot == GRS_SLOT_Z && sync_latch_reg);
endmodule // grs_rate_filter
`default_nettype wire

// File: verilog/grs_pkg.sv
// grs_pkg: constants, field layout and types for the sample-rate and filter config block
package grs_pkg;
    // ==========================================================
    // register map
    localparam logic [6:0] GRS_ADDR_RATE_DIV = 7'h19;
    localparam logic [6:0] GRS_ADDR_SYNC_CFG = 7'h1A;
    localparam logic [7:0] GRS_RATE_DIV_RST = 8'h00;
    localparam logic [7:0] GRS_SYNC_CFG_RST = 8'h00;
    localparam logic [7:0] GRS_RDATA_NONE = 8'h00;

    // ==========================================================
    // sync_filter_config field positions, then bit 0 of the bypass field
    localparam int GRS_CFG_SPARE_BIT = 7;
    localparam int GRS_CFG_KEEP_OLD_BIT = 6;
    localparam int GRS_CFG_SLOT_HI = 5;
    localparam int GRS_CFG_SLOT_LO = 3;
    localparam int GRS_CFG_LP_HI = 2;
    localparam int GRS_CFG_LP_LO = 0;
    localparam int GRS_BYP_BIT0 = 0;

    // ==========================================================
    // encodings
    localparam logic [1:0] GRS_BYP_NONE = 2'b00;
    localparam logic [1:0] GRS_BYP_ALT = 2'b10;
    localparam logic [2:0] GRS_LP_MIN = 3'h0;
    localparam logic [2:0] GRS_LP_MAX = 3'h7;
    localparam logic [2:0] GRS_SLOT_X = 3'h2;
    localparam logic [2:0] GRS_SLOT_Y = 3'h3;
    localparam logic [2:0] GRS_SLOT_Z = 3'h4;
    localparam int GRS_SYNC_BIT = 0;

    // ==========================================================
    // timing: clock and internal rate periods
    localparam int GRS_CLK_NS = 40;
    localparam int GRS_PER_32K_NS = 31250;
    localparam int GRS_PER_8K_NS = 125000;
    localparam int GRS_PER_1K_NS = 1000000;
    localparam int GRS_CYC_32K = GRS_PER_32K_NS / GRS_CLK_NS;
    localparam int GRS_CYC_8K = GRS_PER_8K_NS / GRS_CLK_NS;
    localparam int GRS_CYC_1K_DFLT = GRS_PER_1K_NS / GRS_CLK_NS;
    localparam int GRS_TICK_W = 15;

    // ==========================================================
    // types
    typedef enum logic [1:0] {GRS_RATE_32K, GRS_RATE_8K, GRS_RATE_1K} grs_rate_t;

    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } grs_sample_t;
endpackage

// File: sim/grs_fifo_model.sv
// grs_fifo_model: far-side FIFO stand-in that tracks fill level and raises full
`timescale 1ns/100ps
`default_nettype none
module grs_fifo_model #(
    parameter int P_DEPTH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_clear,
    input wire logic i_push,
    input wire logic i_overwrite,
    output logic o_full
);
    int count = 0;
    // ==========================================================
    // fill level; an overwrite drops one entry for one written, so level holds
    always @(posedge i_clk_sys) begin
        if (i_clear) begin
            count <= 0;
        end else if (i_push && !i_overwrite && count < P_DEPTH) begin
            count <= count + 1;
        end
    end
    assign o_full = (count >= P_DEPTH); // no pops, so full stays until cleared
endmodule // grs_fifo_model
`default_nettype wire

// File: sim/tb_top.sv
// tb_top: register, rate, frame-sync and FIFO policy tests for the rate filter block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
    import grs_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [6:0] addr = 7'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [1:0] byp = 2'b00;
    logic sync = 1'b0;
    logic clr = 1'b0;
    grs_sample_t raw = '0;
    grs_sample_t smp;
    grs_sample_t exp_s;
    logic strobe, push, ovr, full;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int n = 0;
    logic [1:0] t_byp [6] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00};
    logic [7:0] t_cfg [6] = '{8'h01, 8'h01, 8'h00, 8'h07, 8'h01, 8'h06};
    logic [7:0] t_div [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h00};
    int t_per [6] = '{GRS_CYC_32K, GRS_CYC_32K, GRS_CYC_8K, GRS_CYC_8K, 4 * 50, 50};
    // ==========================================================
    // clock, and a ceiling well above the ~17k cycles the tests need
    always #20 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    grs_rate_filter #(.P_CYC_1K(50)) DUT (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_filter_bypass_field(byp), .i_frame_sync_input(sync),
        .i_raw_sample(raw), .i_fifo_full(full), .o_rate_sample(smp),
        .o_sample_strobe(strobe), .o_fifo_push(push), .o_fifo_overwrite(ovr));
    grs_fifo_model FIFO (.i_clk_sys(i_clk_sys), .i_clear(clr), .i_push(push),
        .i_overwrite(ovr), .o_full(full));
    // ==========================================================
    // access tasks; each returns just after a rising edge
    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge i_clk_sys);
        rd <= 1'b0;
        @(posedge i_clk_sys);
        `CHK(rdata, e)
    endtask
    // n ends as the cycle count since the call, so back to back calls give the period
    task automatic wait_strobe();
        n = 0;
        do begin
            @(posedge i_clk_sys);
            n++;
        end while (strobe !== 1'b1 && n < 4000);
        if (n >= 4000) `CHK(1'b0, 1'b1)
    endtask
    // one-cycle pulses on the frame-sync pin and on the model's clear
    task automatic pulse_sync();
        @(posedge i_clk_sys);
        sync <= 1'b1;
        @(posedge i_clk_sys);
        sync <= 1'b0;
    endtask
    task automatic pulse_clr();
        @(posedge i_clk_sys);
        clr <= 1'b1;
        @(posedge i_clk_sys);
        clr <= 1'b0;
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        rd_chk(GRS_ADDR_RATE_DIV, GRS_RATE_DIV_RST);
        rd_chk(GRS_ADDR_SYNC_CFG, GRS_SYNC_CFG_RST);
        wr_reg(7'h1B, 8'h5A);
        rd_chk(7'h1B, GRS_RDATA_NONE);
        // rate table: each mode, divisor on and off
        for (int i = 0; i < 6; i++) begin
            byp <= t_byp[i];
            wr_reg(GRS_ADDR_RATE_DIV, t_div[i]);
            wr_reg(GRS_ADDR_SYNC_CFG, t_cfg[i]);
            rd_chk(GRS_ADDR_RATE_DIV, t_div[i]);
            rd_chk(GRS_ADDR_SYNC_CFG, t_cfg[i]);
            wait_strobe();
            wait_strobe();
            `CHK(n, t_per[i])
        end
        // frame-sync slots; one short pulse must stay latched across slots
        raw <= '{x: 16'hA5A4, y: 16'h5A5A, z: 16'h0FF0};
        for (int s = 2; s < 6; s++) begin
            wr_reg(GRS_ADDR_SYNC_CFG, {2'b00, 3'(s), 3'h1});
            // pulse just after a strobe so neither edge meets a capture
            if (s == 2) begin
                wait_strobe();
                pulse_sync();
            end
            wait_strobe();
            wait_strobe();
            exp_s = raw;
            if (s == 2) exp_s.x[0] = 1'b1;
            if (s == 3) exp_s.y[0] = 1'b1;
            if (s == 4) exp_s.z[0] = 1'b1;
            `CHK(smp, exp_s)
        end
        raw <= '{x: 16'hA5A5, y: 16'h5A5A, z: 16'h0FF0};
        wr_reg(GRS_ADDR_SYNC_CFG, 8'h11);
        wait_strobe();
        pulse_sync();
        wait_strobe();
        wait_strobe();
        `CHK(smp.x, 16'hA5A4)
        // full policy: keep old entries, then overwrite oldest
        wr_reg(GRS_ADDR_SYNC_CFG, 8'h41);
        wait_strobe();
        pulse_clr();
        for (int k = 0; k < 6; k++) begin
            wait_strobe();
            `CHK({push, ovr}, {k < 4, 1'b0})
        end
        wr_reg(GRS_ADDR_SYNC_CFG, 8'h01);
        wait_strobe();
        `CHK({push, ovr}, 2'b11)
        pulse_clr();
        wait_strobe();
        `CHK({push, ovr}, 2'b10)
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
